/* File: shared/asf_map.svh */
// Purpose: constants for the async serial framer
// Assumes: included by bare name
// Notes:   oversample and sample point are in 16x sample ticks; data lengths are in bits
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH
`define ASF_OVERSAMPLE     16
`define ASF_SAMPLE_POINT   8
`define ASF_CLK_MHZ        125
`define ASF_BAUD_DEFAULT   115200
`define ASF_DATA_LONG      8
`define ASF_DATA_SHORT     7
`define ASF_DATA_TINY      5
`define ASF_BUF_DEPTH      2
`endif

/* File: shared/asf_pkg.sv */
// Purpose: shared types for the async serial framer
// Assumes: nothing
// Notes:   states only; numbers live in asf_map.svh
package asf_pkg;
    typedef enum logic [2:0] {ASF_IDLE, ASF_START, ASF_DATA, ASF_EXTRA, ASF_STOP1, ASF_STOP2}
        asf_state_t;
endpackage : asf_pkg

/* File: hw/asf_buf2.sv */
// Purpose: two-entry valid/ready buffer in the receive data path
// Assumes: single clock, synchronous active-high reset
// Notes:   out_valid_o is "data present"; honest full and empty
`timescale 1ns/1ps
module asf_buf2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic [1:0]       cnt_q, cnt_d;
    logic             rd_q, rd_d;
    logic             wr_q, wr_d;
    logic             push, pop;

    // next-state for pointers and storage
    always_comb
    begin
        push   = in_valid_i && (cnt_q != 2'h2);
        pop    = out_ready_i && (cnt_q != 2'h0);
        mem_d  = mem_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        wr_d   = wr_q;
        if (push)
        begin
            mem_d[wr_q] = in_data_i;
            wr_d        = ~wr_q;
        end
        if (pop)
            rd_d = ~rd_q;
        if (push && !pop)
            cnt_d = cnt_q + 2'h1;
        else if (pop && !push)
            cnt_d = cnt_q - 2'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q    <= 2'h0;
            rd_q     <= 1'b0;
            wr_q     <= 1'b0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            rd_q  <= rd_d;
            wr_q  <= wr_d;
            mem_q <= mem_d;
        end
    end

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];
endmodule : asf_buf2

/* File: hw/asf_framer.sv */
// Purpose: full-duplex asynchronous serial framer with event flags
// Assumes: inputs synchronous to clk_i; ext_clk16_i is a synchronous 16x strobe
// Notes:   errors reported as pulses; synchronous mode is not supported
// Contract
// - good character into receive data register sets rx_full_flag, irq if enabled
// - transmit data moved into empty shift register sets tx_empty_flag, irq if enabled
// - last bit sent with no new data sets tx_end_flag, irq if enabled
// - transmitter and receiver run independently, full duplex
// - each direction has a holding register in front of its shift register
// - idle line is high; transmitter sends ones between frames
// - low on idle line is taken as a start bit
// - frame: start low, data lsb first, optional extra bit, one or two stops
// - receiver timing aligns to each start bit falling edge
// - each bit sampled on eighth of sixteen sub-bit ticks
// - four mode bits select the frame format
// - length select 0 gives 8 bits, 1 gives 7, parity and multiprocessor both set give 5; stop select gives 1 or 2
// - parity or multiprocessor alone, or both with length select 1, adds one bit after data
// - receiver checks parity against the chosen odd or even sense
// - with two stop bits only the first is checked
`timescale 1ns/1ps
`include "asf_map.svh"
module asf_framer
    import asf_pkg::*;
#(
    parameter int BAUD = `ASF_BAUD_DEFAULT
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ext_clk_sel_i,     // 1: use ext_clk16_i as 16x tick
    input  wire logic       ext_clk16_i,
    input  wire logic       char_length_sel_i,
    input  wire logic       parity_enable_i,
    input  wire logic       multiproc_enable_i,
    input  wire logic       stop_two_i,
    input  wire logic       parity_sense_i,    // 1: odd
    input  wire logic       tx_enable_i,
    input  wire logic       rx_enable_i,
    input  wire logic       rx_irq_enable_i,
    input  wire logic       tx_irq_enable_i,
    input  wire logic       tx_end_irq_enable_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_mbit_i,
    input  wire logic       tx_write_i,        // write holding reg, clears empty flag
    input  wire logic       rx_read_i,         // read done, clears full flag unless a second word is buffered or one lands that cycle
    output logic [7:0]      rx_data_o,
    output logic            rx_mbit_o,
    output logic            rx_full_flag_o,
    output logic            tx_empty_flag_o,
    output logic            tx_end_flag_o,
    output logic            rx_full_irq_o,
    output logic            tx_empty_irq_o,
    output logic            tx_end_irq_o,
    output logic            parity_err_o,
    output logic            framing_err_o,
    output logic            overrun_err_o,
    input  wire logic       rxd_i,
    output logic            txd_o
);
    localparam int DIV = (`ASF_CLK_MHZ * 1000000) / (BAUD * `ASF_OVERSAMPLE);
    localparam int DW  = (DIV > 1) ? $clog2(DIV) : 1;

    // data bit count for a mode
    function automatic logic [3:0] data_bits(input logic c, input logic p, input logic m);
        if (p && m)
            data_bits = 4'(`ASF_DATA_TINY);
        else if (c)
            data_bits = 4'(`ASF_DATA_SHORT);
        else
            data_bits = 4'(`ASF_DATA_LONG);
    endfunction : data_bits

    // extra bit present: one enable alone, or both with length select 1
    function automatic logic has_extra(input logic c, input logic p, input logic m);
        has_extra = (p ^ m) || (p && m && c);
    endfunction : has_extra

    // extra bit carries parity rather than a multiprocessor flag
    function automatic logic extra_is_par(input logic p, input logic m);
        extra_is_par = p;
    endfunction : extra_is_par

    function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 8; i++)
            if (4'(i) < n)
                p = p ^ d[i];
        par_of = p;
    endfunction : par_of

    // 16x tick: internal divider or external strobe
    logic [DW-1:0] div_q, div_d;
    logic          tick;
    always_comb
    begin
        div_d = (div_q == DW'(DIV - 1)) ? '0 : div_q + 1'b1;
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            div_q <= '0;
        else
            div_q <= div_d;
    end
    assign tick = ext_clk_sel_i ? ext_clk16_i : (div_q == DW'(DIV - 1));

    logic [3:0] nbits;
    logic       xbit;
    logic       xpar;
    assign nbits = data_bits(char_length_sel_i, parity_enable_i, multiproc_enable_i);
    assign xbit  = has_extra(char_length_sel_i, parity_enable_i, multiproc_enable_i);
    assign xpar  = extra_is_par(parity_enable_i, multiproc_enable_i);

    // transmitter, independent of receiver
    asf_state_t tx_st_q, tx_st_d;
    logic [7:0] tx_hold_q, tx_hold_d, tx_sh_q, tx_sh_d;
    logic       tx_hxb_q, tx_hxb_d, tx_xb_q, tx_xb_d;
    logic       tx_empty_q, tx_empty_d, tx_end_q, tx_end_d;
    logic [3:0] tx_sub_q, tx_sub_d, tx_cnt_q, tx_cnt_d;
    logic       txd_q, txd_d;
    logic       tx_load;
    always_comb
    begin
        tx_st_d    = tx_st_q;
        tx_hold_d  = tx_hold_q;
        tx_hxb_d   = tx_hxb_q;
        tx_sh_d    = tx_sh_q;
        tx_xb_d    = tx_xb_q;
        tx_empty_d = tx_empty_q;
        tx_end_d   = tx_end_q;
        tx_sub_d   = tx_sub_q;
        tx_cnt_d   = tx_cnt_q;
        txd_d      = txd_q;
        tx_load    = 1'b0;
        if (tx_write_i)
        begin
            tx_hold_d  = tx_data_i;
            tx_hxb_d   = tx_mbit_i;
            tx_empty_d = 1'b0;
            tx_end_d   = 1'b0;
        end
        if (tick && tx_st_q != ASF_IDLE)
            tx_sub_d = tx_sub_q + 4'h1;
        // bit ends when the sub-tick counter wraps
        if (tick && tx_sub_q == 4'hf)
        begin
            case (tx_st_q)
                ASF_START:
                begin
                    tx_st_d = ASF_DATA;
                    txd_d   = tx_sh_q[0];
                    tx_sh_d = tx_sh_q >> 1;
                    tx_cnt_d = 4'h1;
                end
                ASF_DATA:
                    if (tx_cnt_q == nbits)
                    begin
                        tx_st_d = xbit ? ASF_EXTRA : ASF_STOP1;
                        txd_d   = xbit ? tx_xb_q : 1'b1;
                    end
                    else
                    begin
                        txd_d    = tx_sh_q[0];
                        tx_sh_d  = tx_sh_q >> 1;
                        tx_cnt_d = tx_cnt_q + 4'h1;
                    end
                ASF_EXTRA:
                begin
                    tx_st_d = ASF_STOP1;
                    txd_d   = 1'b1;
                end
                ASF_STOP1, ASF_STOP2:
                    if (tx_st_q == ASF_STOP1 && stop_two_i)
                        tx_st_d = ASF_STOP2;
                    else
                    begin
                        tx_st_d = ASF_IDLE;
                        if (tx_empty_d && !tx_write_i)
                            tx_end_d = 1'b1;
                    end
                default:
                    tx_st_d = ASF_IDLE;
            endcase
        end
        // load shift register when it is empty; a same-cycle write holds off the load, so the write clear stands
        if (tx_enable_i && tx_st_d == ASF_IDLE && !tx_empty_q && !tx_write_i)
        begin
            tx_load    = 1'b1;
            tx_sh_d    = tx_hold_q;
            tx_xb_d    = xpar ? par_of(tx_hold_q, nbits, parity_sense_i) : tx_hxb_q;
            tx_empty_d = 1'b1;
            tx_end_d   = 1'b0;
            tx_st_d    = ASF_START;
            tx_sub_d   = 4'h0;
            txd_d      = 1'b0;
        end
        else if (tx_st_d == ASF_IDLE)
            txd_d = 1'b1;
        if (!tx_enable_i)
        begin
            tx_st_d    = ASF_IDLE;
            txd_d      = 1'b1;
            tx_empty_d = 1'b1;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_st_q    <= ASF_IDLE;
            tx_hold_q  <= 8'h00;
            tx_hxb_q   <= 1'b0;
            tx_sh_q    <= 8'h00;
            tx_xb_q    <= 1'b0;
            tx_empty_q <= 1'b1;
            tx_end_q   <= 1'b1;
            tx_sub_q   <= 4'h0;
            tx_cnt_q   <= 4'h0;
            txd_q      <= 1'b1;
        end
        else
        begin
            tx_st_q    <= tx_st_d;
            tx_hold_q  <= tx_hold_d;
            tx_hxb_q   <= tx_hxb_d;
            tx_sh_q    <= tx_sh_d;
            tx_xb_q    <= tx_xb_d;
            tx_empty_q <= tx_empty_d;
            tx_end_q   <= tx_end_d;
            tx_sub_q   <= tx_sub_d;
            tx_cnt_q   <= tx_cnt_d;
            txd_q      <= txd_d;
        end
    end

    // receiver
    asf_state_t rx_st_q, rx_st_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [3:0] rx_sub_q, rx_sub_d, rx_cnt_q, rx_cnt_d;
    logic       rx_x_q, rx_x_d, rx_prev_q;
    logic       rx_full_q, rx_full_d;
    logic       done, par_bad, frm_bad, ovr;
    logic       buf_rdy, buf_vld;
    logic [8:0] buf_out;
    always_comb
    begin
        rx_st_d  = rx_st_q;
        rx_sh_d  = rx_sh_q;
        rx_sub_d = rx_sub_q;
        rx_cnt_d = rx_cnt_q;
        rx_x_d   = rx_x_q;
        done     = 1'b0;
        par_bad  = 1'b0;
        frm_bad  = 1'b0;
        case (rx_st_q)
            ASF_IDLE:
                if (rx_enable_i && rx_prev_q && !rxd_i)
                begin
                    rx_st_d  = ASF_START;
                    rx_sub_d = 4'h0;
                end
            ASF_START, ASF_DATA, ASF_EXTRA, ASF_STOP1:
                if (tick)
                begin
                    rx_sub_d = rx_sub_q + 4'h1;
                    if (rx_sub_q == 4'(`ASF_SAMPLE_POINT - 1))
                    begin
                        rx_sub_d = 4'h0;
                        if (rx_st_q == ASF_START)
                        begin
                            rx_st_d  = rxd_i ? ASF_IDLE : ASF_DATA; // glitch rejected
                            rx_cnt_d = 4'h0;
                            rx_sub_d = 4'(`ASF_SAMPLE_POINT - `ASF_OVERSAMPLE);
                        end
                        else if (rx_st_q == ASF_DATA)
                        begin
                            rx_sh_d  = {rxd_i, rx_sh_q[7:1]};
                            rx_cnt_d = rx_cnt_q + 4'h1;
                            if (rx_cnt_d == nbits)
                                rx_st_d = xbit ? ASF_EXTRA : ASF_STOP1;
                            rx_sub_d = 4'(`ASF_SAMPLE_POINT - `ASF_OVERSAMPLE);
                        end
                        else if (rx_st_q == ASF_EXTRA)
                        begin
                            rx_x_d   = rxd_i;
                            rx_st_d  = ASF_STOP1;
                            rx_sub_d = 4'(`ASF_SAMPLE_POINT - `ASF_OVERSAMPLE);
                        end
                        else
                        begin
                            // only the first stop bit is checked
                            rx_st_d = ASF_IDLE;
                            done    = 1'b1;
                            frm_bad = !rxd_i;
                            par_bad = xbit && xpar &&
                                (rx_x_q != par_of(rx_sh_q >> (4'h8 - nbits), nbits,
                                                  parity_sense_i));
                        end
                    end
                end
            default:
                rx_st_d = ASF_IDLE;
        endcase
        if (!rx_enable_i)
            rx_st_d = ASF_IDLE;
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rx_st_q   <= ASF_IDLE;
            rx_sh_q   <= 8'h00;
            rx_sub_q  <= 4'h0;
            rx_cnt_q  <= 4'h0;
            rx_x_q    <= 1'b0;
            rx_prev_q <= 1'b1;
            rx_full_q <= 1'b0;
        end
        else
        begin
            rx_st_q   <= rx_st_d;
            rx_sh_q   <= rx_sh_d;
            rx_sub_q  <= rx_sub_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_x_q    <= rx_x_d;
            rx_prev_q <= rxd_i;       // idle line is mark
            rx_full_q <= rx_full_d;
        end
    end

    // good character pushed into holding buffer; overrun when buffer full
    logic       push_ok;
    logic [7:0] rx_aligned;
    assign rx_aligned = rx_sh_q >> (4'h8 - nbits);
    assign push_ok    = done && !frm_bad && !par_bad && buf_rdy;
    assign ovr        = done && !frm_bad && !par_bad && !buf_rdy;
    always_comb
    begin
        // set beats a same-cycle read clear; a second buffered word keeps the flag up
        rx_full_d = push_ok || (buf_vld && !(rx_read_i && buf_rdy));
    end

    asf_buf2 #(
        .WIDTH (9)
    ) u_rx_buf (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push_ok),
        .in_ready_o  (buf_rdy),
        .in_data_i   ({rx_x_q, rx_aligned}),
        .out_valid_o (buf_vld),
        .out_ready_i (rx_read_i && rx_full_q),
        .out_data_o  (buf_out)
    );

    // error pulses registered for clean outputs
    logic pr_q, fe_q, oe_q;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pr_q <= 1'b0;
            fe_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            pr_q <= par_bad;
            fe_q <= frm_bad;
            oe_q <= ovr;
        end
    end

    assign rx_data_o       = buf_out[7:0];
    assign rx_mbit_o       = buf_out[8];
    assign rx_full_flag_o  = rx_full_q;
    assign tx_empty_flag_o = tx_empty_q;
    assign tx_end_flag_o   = tx_end_q;
    assign rx_full_irq_o   = rx_full_q && rx_irq_enable_i;
    assign tx_empty_irq_o  = tx_empty_q && tx_irq_enable_i;
    assign tx_end_irq_o    = tx_end_q && tx_end_irq_enable_i;
    assign parity_err_o    = pr_q;
    assign framing_err_o   = fe_q;
    assign overrun_err_o   = oe_q;
    assign txd_o           = txd_q;
endmodule : asf_framer

/* File: dv/asf_framer_checker.sv */
// Purpose: port-level assertions for the async serial framer
// Assumes: one clock, sync active-high reset, one clock per 16x tick
// Notes:   bound into asf_framer below
`timescale 1ns/1ps
module asf_framer_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic tx_write_i,
    input wire logic rxd_i,
    input wire logic rx_irq_enable_i,
    input wire logic tx_irq_enable_i,
    input wire logic tx_end_irq_enable_i,
    input wire logic txd_o,
    input wire logic rx_full_flag_o,
    input wire logic tx_empty_flag_o,
    input wire logic tx_end_flag_o,
    input wire logic rx_full_irq_o,
    input wire logic tx_empty_irq_o,
    input wire logic tx_end_irq_o,
    input wire logic parity_err_o,
    input wire logic framing_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // load walk: holding reg taken, then the start bit goes out
    sequence s_load;
        !tx_empty_flag_o ##1 (tx_empty_flag_o && !txd_o);
    endsequence
    // a low level on the line lasts at least one whole bit
    sequence s_low16;
        (!txd_o)[*8] ##1 (!txd_o)[*8];
    endsequence
    AST_RXF_LEVEL: assert property (rx_full_irq_o == (rx_full_flag_o && rx_irq_enable_i))
        else $error("rx full request does not follow flag and enable");
    AST_TXE_LEVEL: assert property (tx_empty_irq_o == (tx_empty_flag_o && tx_irq_enable_i))
        else $error("tx empty request does not follow flag and enable");
    AST_END_LEVEL: assert property (tx_end_irq_o == (tx_end_flag_o && tx_end_irq_enable_i))
        else $error("tx end request does not follow flag and enable");
    AST_TX_START: assert property (tx_write_i && tx_end_flag_o |=> s_load)
        else $error("idle write did not load and start");
    AST_BIT_LEN: assert property ($fell(txd_o) |-> s_low16)
        else $error("low bit shorter than sixteen ticks");
    AST_IDLE_HIGH: assert property (tx_end_flag_o |-> txd_o)
        else $error("line not at mark while transmitter ended");
    AST_END_CLEAR: assert property (tx_write_i |=> !tx_end_flag_o)
        else $error("write did not clear tx end");
    AST_END_AFTER_STOP: assert property ($rose(tx_end_flag_o) |-> txd_o && $past(txd_o))
        else $error("tx end raised outside a stop bit");
    AST_RX_PUSH: assert property ($rose(rx_full_flag_o) |-> $past(rxd_i, 2))
        else $error("word stored without a high stop bit");
    AST_FERR_LOW: assert property (framing_err_o |-> !$past(rxd_i, 2) && !$past(rxd_i, 4))
        else $error("framing error without a low first stop");
    AST_PERR_NOSTORE: assert property (parity_err_o && !$past(rx_full_flag_o)
        |-> !rx_full_flag_o ##1 !rx_full_flag_o)
        else $error("word with bad parity was stored");
endmodule : asf_framer_checker

bind asf_framer asf_framer_checker i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .tx_write_i(tx_write_i), .rxd_i(rxd_i), .rx_irq_enable_i(rx_irq_enable_i),
    .tx_irq_enable_i(tx_irq_enable_i), .tx_end_irq_enable_i(tx_end_irq_enable_i),
    .txd_o(txd_o), .rx_full_flag_o(rx_full_flag_o), .tx_empty_flag_o(tx_empty_flag_o),
    .tx_end_flag_o(tx_end_flag_o), .rx_full_irq_o(rx_full_irq_o),
    .tx_empty_irq_o(tx_empty_irq_o), .tx_end_irq_o(tx_end_irq_o),
    .parity_err_o(parity_err_o), .framing_err_o(framing_err_o));

/* File: dv/asf_remote.sv */
// Purpose: remote serial device on the far side of the line pair
// Assumes: 16 clocks per bit, line idles at mark
// Notes:   bench calls send; each capture is pulsed on got_o
`timescale 1ns/1ps
module asf_remote (
    input  wire logic       clk_i,
    input  wire logic       txd_i,
    input  wire logic [3:0] rx_len_i,
    output logic            rxd_o,
    output logic            got_o,
    output logic [10:0]     word_o
);
    logic [10:0] w;
    int          i;
    initial {rxd_o, got_o, word_o} = {1'b1, 1'b0, 11'h7ff};
    // frame bits leave lsb first, 16 clocks each, then back to mark
    task automatic send(input logic [11:0] f, input int n);
        int k;
        for (k = 0; k < n; k++)
        begin
            @(negedge clk_i) rxd_o <= f[k];
            repeat (15) @(negedge clk_i);
        end
        @(negedge clk_i) rxd_o <= 1'b1;
    endtask : send
    // capture: align to start edge, sample mid bit; got moves on posedge to avoid races
    always
    begin
        @(negedge txd_i);
        w = 11'h7ff;
        repeat (8) @(negedge clk_i);
        for (i = 0; i < int'(rx_len_i); i++)
        begin
            repeat (16) @(negedge clk_i);
            w[i] = txd_i;
        end
        @(posedge clk_i) {word_o, got_o} = {w, 1'b1};
        @(posedge clk_i) got_o = 1'b0;
    end
endmodule : asf_remote

/* File: dv/asf_framer_tb.sv */
// Purpose: self-checking bench for the async serial framer
// Assumes: BAUD chosen so one clock is one 16x tick
// Notes:   drivers note expectations in queues, watchers pop and compare
`timescale 1ns/1ps
module asf_framer_tb;
    localparam int BAUD = 7812500; // 125 MHz / (16 * BAUD) = 1 clock per tick
    logic        clk_i = 1'b0, sys_rst_i = 1'b1;
    logic        ln = 1'b0, pa = 1'b0, mu = 1'b0, stp = 1'b0, ps = 1'b0, xs = 1'b0;
    logic        rxe = 1'b0, txe = 1'b0, tee = 1'b0, rd_en = 1'b1;
    logic [7:0]  tx_data = 8'h00, rx_data, r;
    logic        tx_xb = 1'b0, tx_write = 1'b0, rx_read = 1'b0;
    logic        rx_xb, rx_full, tx_empty, tx_end, rq, tq, eq, perr, ferr, oerr;
    logic        rxd, txd, got;
    logic [3:0]  rx_len = 4'h0;
    logic [10:0] word;
    logic [11:0] f;
    logic [9:0]  rx_note;
    logic [10:0] exp_tx[$];
    logic [9:0]  exp_rx[$];
    int num_errors = 0, checks_done = 0, seed = 97, perr_n = 0, ferr_n = 0, oerr_n = 0;
    int gap = 0;
    always #4 clk_i = ~clk_i;
    asf_framer #(.BAUD(BAUD)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ext_clk_sel_i(xs), .ext_clk16_i(1'b1), .char_length_sel_i(ln),
        .parity_enable_i(pa), .multiproc_enable_i(mu), .stop_two_i(stp),
        .parity_sense_i(ps), .tx_enable_i(1'b1), .rx_enable_i(1'b1),
        .rx_irq_enable_i(rxe), .tx_irq_enable_i(txe), .tx_end_irq_enable_i(tee),
        .tx_data_i(tx_data), .tx_mbit_i(tx_xb), .tx_write_i(tx_write),
        .rx_read_i(rx_read), .rx_data_o(rx_data), .rx_mbit_o(rx_xb),
        .rx_full_flag_o(rx_full), .tx_empty_flag_o(tx_empty), .tx_end_flag_o(tx_end),
        .rx_full_irq_o(rq), .tx_empty_irq_o(tq), .tx_end_irq_o(eq),
        .parity_err_o(perr), .framing_err_o(ferr), .overrun_err_o(oerr),
        .rxd_i(rxd), .txd_o(txd));
    asf_remote i_rem (.clk_i(clk_i), .txd_i(txd), .rx_len_i(rx_len), .rxd_o(rxd),
        .got_o(got), .word_o(word));
    // format helpers from the four mode bits
    function automatic int ndat(); return (pa && mu) ? 5 : (ln ? 7 : 8); endfunction
    function automatic int nex(); return ((pa ^ mu) || (pa && mu && ln)) ? 1 : 0; endfunction
    function automatic int nfr(); return 1 + ndat() + nex() + (stp ? 2 : 1); endfunction
    function automatic logic [7:0] dmask(); return 8'hff >> (8 - ndat()); endfunction
    function automatic logic pbit(input logic [7:0] d); return ^(d & dmask()) ^ ps; endfunction
    function automatic logic xbit(input logic [7:0] d, input logic m);
        return pa ? pbit(d) : m;
    endfunction : xbit
    function automatic logic [11:0] frame(input logic [7:0] d, input logic x, input logic s);
        logic [11:0] v;
        int          i;
        v = 12'hffe;
        for (i = 0; i < ndat(); i++) v[i + 1] = d[i];
        if (nex() != 0) v[ndat() + 1] = x;
        v[ndat() + nex() + 1] = s;
        return v;
    endfunction : frame
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [10:0] e, input logic [10:0] s);
        checks_done++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic fail(input string what);
        chk(what, 11'h1, 11'h0);
        end_sim();
    endtask : fail
    // one write per empty flag; the second lands in the holding reg mid frame
    task automatic send_tx(input logic [7:0] d, input logic m);
        int k;
        for (k = 0; k < 800 && tx_empty !== 1'b1; k++) @(negedge clk_i);
        if (k == 800) fail("tx empty wait");
        exp_tx.push_back(11'(frame(d, xbit(d, m), 1'b1) >> 1));
        {tx_data, tx_xb, tx_write} <= {d, m, 1'b1};
        @(negedge clk_i) tx_write <= 1'b0;
        @(negedge clk_i);
    endtask : send_tx
    task automatic wait_idle();
        int k;
        for (k = 0; k < 3000 && !(tx_end === 1'b1 && exp_tx.size() == 0
            && exp_rx.size() == 0); k++) @(negedge clk_i);
        if (k == 3000) fail("idle wait");
    endtask : wait_idle
    // one mode: two back-to-back transmits while a word is received
    task automatic do_mode(input logic [3:0] m);
        logic [7:0] a, b;
        logic       rm;
        {ln, pa, mu, stp} = m;
        {ps, rxe, txe, tee, xs} = 5'($random(seed));
        {a, b, r} = 24'($random(seed));
        rm = 1'($random(seed));
        rx_len = 4'(ndat() + nex() + 1);
        exp_rx.push_back({nex() != 0, xbit(r, rm), r & dmask()});
        fork
            begin send_tx(a, rm); send_tx(b, ~rm); end
            i_rem.send(frame(r, xbit(r, rm), 1'b1), nfr());
        join
        wait_idle();
        $display("test mode %h done", m);
    endtask : do_mode
    // watcher: remote captures and error pulses
    always @(negedge clk_i)
    begin
        if (got === 1'b1 && exp_tx.size() == 0) fail("tx frame unexpected");
        if (got === 1'b1) chk("tx frame", exp_tx.pop_front(), word);
        perr_n += int'(perr === 1'b1);
        ferr_n += int'(ferr === 1'b1);
        oerr_n += int'(oerr === 1'b1);
    end
    // reader: takes the buffer head; gap covers the flag update
    always @(negedge clk_i)
    begin
        if (gap > 0)
            gap <= gap - 1;
        else if (rd_en && rx_full === 1'b1)
        begin
            if (exp_rx.size() == 0) fail("rx word unexpected");
            rx_note = exp_rx.pop_front();
            chk("rx word", {2'h0, rx_note[9] & rx_note[8], rx_note[7:0]},
                {2'h0, rx_note[9] & rx_xb, rx_data});
            gap <= 2;
        end
        rx_read <= (gap == 0) && rd_en && (rx_full === 1'b1);
    end
    initial
    begin
        repeat (20) @(negedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        for (int m = 0; m < 16; m++) do_mode(4'(m));
        // errors: bad parity, bad first stop, bad second stop only
        {ln, pa, mu, stp, ps} = 5'b01001;
        r = 8'h5a;
        i_rem.send(frame(r, ~pbit(r), 1'b1), 11);
        i_rem.send(frame(r, pbit(r), 1'b0), 11);
        stp = 1'b1;
        f = frame(r, pbit(r), 1'b1);
        f[11] = 1'b0;
        exp_rx.push_back({2'b11 & {1'b1, pbit(r)}, r});
        // the low second stop reads as a new start, so an all-ones word follows
        exp_rx.push_back(10'h3ff);
        i_rem.send(f, 12);
        wait_idle();
        chk("parity errors", 11'h1, 11'(perr_n));
        chk("framing errors", 11'h1, 11'(ferr_n));
        $display("test errors done");
        // overrun: reader stalls, third word is refused
        {ln, pa, mu, stp} = 4'b0000;
        rd_en <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            r = 8'($random(seed));
            if (k < 2) exp_rx.push_back({2'b00, r});
            i_rem.send(frame(r, 1'b0, 1'b1), 10);
        end
        chk("overrun errors", 11'h1, 11'(oerr_n));
        chk("full held", 11'h1, {10'h0, rx_full});
        rd_en <= 1'b1;
        wait_idle();
        $display("test overrun done");
        end_sim();
    end
endmodule : asf_framer_tb
